// ### pkg/mfi_cfg.svh
`ifndef MFI_CFG_SVH
`define MFI_CFG_SVH

// ----------------------------------------------------------------
// Register map (word index = byte address / 4)
// ----------------------------------------------------------------
`define MFI_A_GLOBAL 4'h0
`define MFI_A_CHEN 4'h1
`define MFI_A_CHFLAG 4'h2
`define MFI_A_SRCEN 4'h3
`define MFI_A_SRCFLAG 4'h4
`define MFI_A_SRCSET 4'h5
`define MFI_A_SRCCLR 4'h6
`define MFI_A_MAP 4'h7
`define MFI_A_IRQ_STAT 4'h8
`define MFI_A_IRQ_CLR 4'h9
`define MFI_A_IRQ_EN 4'ha
`define MFI_A_CORE 4'hb
`define MFI_A_VECBASE 4'hc

// ----------------------------------------------------------------
// Source bit positions
// ----------------------------------------------------------------
`define MFI_SRC_ADC 0
`define MFI_SRC_UART 1
`define MFI_SRC_EEP 2
`define MFI_SRC_LVD 3
`define MFI_SRC_TM0 4

// ----------------------------------------------------------------
// Status event bits
// ----------------------------------------------------------------
`define MFI_EV_VECTOR 0
`define MFI_EV_WAKE 1
`define MFI_EV_STACKFULL 2

`define MFI_VEC_BASE_RST 16'h0010
`define MFI_VEC_STEP 16'h0004
`define MFI_MAP_RST 32'h0000_0000

`endif

// ### pkg/mfi_pkg.sv
package mfi_pkg;

    typedef enum logic [1:0]
    {
        MFI_IDLE = 2'b00,
        MFI_CALL = 2'b01,
        MFI_SERVE = 2'b11
    } mfi_state_t;

endpackage : mfi_pkg

// ### hdl/mfi_prio.sv
module mfi_prio
    import mfi_pkg::*;
#(
    parameter int N = 6
)
(
    input wire logic [N-1:0] req,
    output logic found,
    output logic [2:0] index
);

    // Lowest-numbered request wins
    always_comb
    begin
        found = 1'b0;
        index = 3'h0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                found = 1'b1;
                index = 3'(i);
            end
        end
    end

endmodule : mfi_prio

// ### hdl/mfi_merge.sv
// Local design decisions: strobed register access and the address map.
`include "mfi_cfg.svh"

// Summary of operation
// - Up to six shared channels, sources only.
// - Any enabled member source flag rise sets channel flag.
// - Enabled channel, stack room: call vector.
// - Service clears channel flag and global enable.
// - Source flags survive service; software clears.
// - Conversion done sets flag; three enables gate.
// - Six serial conditions raise serial request.
// - EEPROM write end sets flag; enables gate.
// - Supply drop sets flag; enables gate.
// - Each timer: A and P match, flag+enable.
// - Timer match vectors with three enables.
// - Any flag rising edge wakes the core.
// - Flags hold until serviced or cleared.
// - Entry pushes only the program counter.
// - Return-from-interrupt sets global enable.
// - Plain return leaves global enable unchanged.
module mfi_merge
    import mfi_pkg::*;
#(
    parameter int NCH = 6,
    parameter int NTM = 2,
    parameter int PCW = 16
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic conversion_done,
    input wire logic [5:0] serial_port_status_flags,
    input wire logic eeprom_write_end,
    input wire logic supply_drop_detector,
    input wire logic [NTM-1:0] tm_match_a,
    input wire logic [NTM-1:0] tm_match_p,
    input wire logic stack_full,
    input wire logic [PCW-1:0] core_pc,
    input wire logic call_ack,
    input wire logic plain_return,
    input wire logic return_from_interrupt,
    output logic call_req,
    output logic [PCW-1:0] call_vector,
    output logic push_pc,
    output logic [PCW-1:0] push_pc_value,
    output logic wake_up,
    output logic irq
);

    localparam int NSRC = 4 + 2 * NTM;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    mfi_state_t state_r;
    logic global_interrupt_enable_r;
    logic [NCH-1:0] shared_channel_enable_r;
    logic [NCH-1:0] shared_channel_request_flag_r;
    logic [NSRC-1:0] src_en_r;
    logic [NSRC-1:0] src_flag_r;
    logic [NSRC-1:0] src_flag_d_r;
    logic [NSRC*3-1:0] map_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_en_r;
    logic [2:0] serv_ch_r;
    logic [PCW-1:0] vec_base_r;
    logic [NSRC-1:0] src_event;
    logic [NSRC-1:0] src_set_wr;
    logic [NSRC-1:0] src_clr_wr;
    logic [NCH-1:0] ch_set;
    logic [NCH-1:0] ch_pend;
    logic pend_found;
    logic [2:0] pend_idx;
    logic serve_now;
    logic wake_nxt;
    logic [2:0] irq_ev;

    wire logic wr_global = clk_en && reg_wr && reg_addr == `MFI_A_GLOBAL;

    // ----------------------------------------------------------------
    // Source events
    // ----------------------------------------------------------------
    always_comb
    begin
        src_event = '0;
        src_event[`MFI_SRC_ADC] = conversion_done;
        src_event[`MFI_SRC_UART] = |serial_port_status_flags;
        src_event[`MFI_SRC_EEP] = eeprom_write_end;
        src_event[`MFI_SRC_LVD] = supply_drop_detector;
        for (int t = 0; t < NTM; t++)
        begin
            src_event[`MFI_SRC_TM0 + 2 * t] = tm_match_a[t];
            src_event[`MFI_SRC_TM0 + 2 * t + 1] = tm_match_p[t];
        end
        src_set_wr = (clk_en && reg_wr && reg_addr == `MFI_A_SRCSET) ? reg_wdata[NSRC-1:0] : '0;
        src_clr_wr = (clk_en && reg_wr && reg_addr == `MFI_A_SRCCLR) ? reg_wdata[NSRC-1:0] : '0;
    end

    // Flags hold until software clears; hardware set wins over clear
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            src_flag_r <= '0;
        else if (clk_en)
            src_flag_r <= (src_flag_r & ~src_clr_wr) | src_event | src_set_wr;
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            src_flag_d_r <= '0;
        else if (clk_en)
            src_flag_d_r <= src_flag_r;
    end

    // ----------------------------------------------------------------
    // Channel membership: each source names its channel
    // ----------------------------------------------------------------
    genvar gc;
    generate
        for (gc = 0; gc < NCH; gc++)
        begin : g_ch
            logic [NSRC-1:0] member;
            for (genvar s = 0; s < NSRC; s++)
            begin : g_src
                assign member[s] = map_r[s*3 +: 3] == 3'(gc);
            end
            // Rising source flag with its enable sets the channel
            assign ch_set[gc] = |(member & src_en_r & src_flag_r & ~src_flag_d_r);
        end
    endgenerate

    always_comb
    begin
        ch_pend = shared_channel_request_flag_r & shared_channel_enable_r;
        serve_now = state_r == MFI_IDLE && pend_found && global_interrupt_enable_r && !stack_full;
    end

    mfi_prio #(.N(NCH)) u_prio
    (
        .req(ch_pend),
        .found(pend_found),
        .index(pend_idx)
    );

    // ----------------------------------------------------------------
    // Vectoring sequence
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            state_r <= MFI_IDLE;
            serv_ch_r <= 3'h0;
        end
        else if (clk_en)
        begin
            case (state_r)
                MFI_IDLE:
                    if (serve_now)
                    begin
                        state_r <= MFI_CALL;
                        serv_ch_r <= pend_idx;
                    end
                MFI_CALL:
                    if (call_ack)
                        state_r <= MFI_SERVE;
                MFI_SERVE:
                    // Nesting is left to software: done once any return is seen
                    if (plain_return || return_from_interrupt)
                        state_r <= MFI_IDLE;
                default:
                    state_r <= MFI_IDLE;
            endcase
        end
    end

    always_comb
    begin
        call_req = state_r == MFI_CALL;
        call_vector = vec_base_r + PCW'(serv_ch_r) * `MFI_VEC_STEP;
        push_pc = state_r == MFI_CALL && call_ack;
        push_pc_value = core_pc;
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            shared_channel_request_flag_r <= '0;
        else if (clk_en)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                if (ch_set[c])
                    shared_channel_request_flag_r[c] <= 1'b1;
                else if (serve_now && pend_idx == 3'(c))
                    shared_channel_request_flag_r[c] <= 1'b0;
                else if (reg_wr && reg_addr == `MFI_A_CHFLAG && !reg_wdata[c])
                    shared_channel_request_flag_r[c] <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            global_interrupt_enable_r <= 1'b0;
        else if (clk_en)
        begin
            if (serve_now)
                global_interrupt_enable_r <= 1'b0;
            else if (return_from_interrupt)
                global_interrupt_enable_r <= 1'b1;
            else if (wr_global)
                global_interrupt_enable_r <= reg_wdata[0];
            // Plain return leaves the enable as it is
        end
    end

    // ----------------------------------------------------------------
    // Wake-up on any flag rising, enables ignored
    // ----------------------------------------------------------------
    always_comb
    begin
        wake_nxt = |(src_flag_r & ~src_flag_d_r) || |ch_set;
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            wake_up <= 1'b0;
        else if (clk_en)
            wake_up <= wake_nxt;
    end

    // ----------------------------------------------------------------
    // Software configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            shared_channel_enable_r <= '0;
            src_en_r <= '0;
            map_r <= (NSRC*3)'(`MFI_MAP_RST);
            vec_base_r <= PCW'(`MFI_VEC_BASE_RST);
            irq_en_r <= 3'h0;
        end
        else if (clk_en && reg_wr)
        begin
            case (reg_addr)
                `MFI_A_CHEN: shared_channel_enable_r <= reg_wdata[NCH-1:0];
                `MFI_A_SRCEN: src_en_r <= reg_wdata[NSRC-1:0];
                `MFI_A_MAP: map_r <= reg_wdata[NSRC*3-1:0];
                `MFI_A_VECBASE: vec_base_r <= reg_wdata[PCW-1:0];
                `MFI_A_IRQ_EN: irq_en_r <= reg_wdata[2:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Event status, set beats clear
    // ----------------------------------------------------------------
    always_comb
    begin
        irq_ev = 3'h0;
        irq_ev[`MFI_EV_VECTOR] = serve_now;
        irq_ev[`MFI_EV_WAKE] = wake_nxt;
        irq_ev[`MFI_EV_STACKFULL] = state_r == MFI_IDLE && pend_found && global_interrupt_enable_r && stack_full;
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            irq_stat_r <= 3'h0;
        else if (clk_en)
        begin
            if (reg_wr && reg_addr == `MFI_A_IRQ_CLR)
                irq_stat_r <= (irq_stat_r & ~reg_wdata[2:0]) | irq_ev;
            else
                irq_stat_r <= irq_stat_r | irq_ev;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            irq <= 1'b0;
        else if (clk_en)
            irq <= |(irq_stat_r & irq_en_r);
    end

    // ----------------------------------------------------------------
    // Read port: data in the cycle after the strobe
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            reg_rdata <= 32'h0000_0000;
        else if (clk_en)
        begin
            reg_rdata <= 32'h0000_0000;
            if (reg_rd)
            begin
                case (reg_addr)
                    `MFI_A_GLOBAL: reg_rdata <= 32'(global_interrupt_enable_r);
                    `MFI_A_CHEN: reg_rdata <= 32'(shared_channel_enable_r);
                    `MFI_A_CHFLAG: reg_rdata <= 32'(shared_channel_request_flag_r);
                    `MFI_A_SRCEN: reg_rdata <= 32'(src_en_r);
                    `MFI_A_SRCFLAG: reg_rdata <= 32'(src_flag_r);
                    `MFI_A_MAP: reg_rdata <= 32'(map_r);
                    `MFI_A_IRQ_STAT: reg_rdata <= 32'(irq_stat_r);
                    `MFI_A_IRQ_EN: reg_rdata <= 32'(irq_en_r);
                    `MFI_A_CORE: reg_rdata <= {24'h0, 1'b0, serv_ch_r, 2'b00, state_r};
                    `MFI_A_VECBASE: reg_rdata <= 32'(vec_base_r);
                    default: reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : mfi_merge

// ### sim/mfi_merge_props.sv
`include "mfi_cfg.svh"

module mfi_merge_props
#(
    parameter int PCW = 16
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic stack_full,
    input wire logic [PCW-1:0] core_pc,
    input wire logic call_ack,
    input wire logic plain_return,
    input wire logic return_from_interrupt,
    input wire logic call_req,
    input wire logic push_pc,
    input wire logic [PCW-1:0] push_pc_value,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // ----------------------------------------------------------------
    // Service window tracker
    // ----------------------------------------------------------------
    logic serve_r;
    always_ff @(posedge core_clk or posedge reset)
        if (reset)
            serve_r <= 1'b0;
        else if (call_req && call_ack)
            serve_r <= 1'b1;
        else if (plain_return || return_from_interrupt)
            serve_r <= 1'b0;

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    push_value_a: assert property (push_pc |-> push_pc_value == core_pc)
        else $error("pushed value differs from core pc");
    push_when_a: assert property (push_pc == (call_req && call_ack))
        else $error("push not tied to accepted call");
    call_hold_a: assert property (call_req && !call_ack |=> call_req)
        else $error("call request dropped before ack");
    call_drop_a: assert property (call_req && call_ack |=> !call_req)
        else $error("call request stays after ack");
    stack_block_a: assert property ($rose(call_req) |-> !$past(stack_full))
        else $error("call taken with full stack");
    serve_block_a: assert property (serve_r |-> !call_req)
        else $error("new call inside service routine");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    irq_mask_a: assert property (reg_wr && reg_addr == `MFI_A_IRQ_EN && reg_wdata == 32'h0 |=> ##1 !irq)
        else $error("irq high with all enables off");
endmodule : mfi_merge_props

bind mfi_merge mfi_merge_props #(.PCW(PCW)) mfi_merge_props_i (.core_clk(core_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stack_full(stack_full), .core_pc(core_pc), .call_ack(call_ack), .plain_return(plain_return),
    .return_from_interrupt(return_from_interrupt), .call_req(call_req), .push_pc(push_pc),
    .push_pc_value(push_pc_value), .irq(irq));

// ### sim/mfi_core_model.sv
module mfi_core_model
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic call_req,
    input wire logic [1:0] ack_wait,
    input wire logic ret_go,
    input wire logic use_return_from_interrupt,
    output logic call_ack,
    output logic plain_return,
    output logic return_from_interrupt,
    output logic [15:0] core_pc
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_r;
    logic isr_r;
    logic ret_r;

    // Pc keeps moving so a stale push value shows up
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            cnt_r <= 2'h0;
            isr_r <= 1'b0;
            ret_r <= 1'b0;
            call_ack <= 1'b0;
            core_pc <= 16'h0100;
        end
        else
        begin
            core_pc <= core_pc + 16'h0001;
            call_ack <= 1'b0;
            ret_r <= 1'b0;
            cnt_r <= call_req ? cnt_r + 2'h1 : 2'h0;
            if (call_req && !call_ack && cnt_r >= ack_wait)
            begin
                call_ack <= 1'b1;
                isr_r <= 1'b1;
            end
            if (ret_go && isr_r)
            begin
                ret_r <= 1'b1;
                isr_r <= 1'b0;
            end
        end
    end
    assign return_from_interrupt = ret_r && use_return_from_interrupt;
    assign plain_return = ret_r && !use_return_from_interrupt;
endmodule : mfi_core_model

// ### sim/test_multi_function_interrupt_merge.sv
module test_multi_function_interrupt_merge;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] src = 8'h00;
    logic [5:0] ser = 6'h00;
    logic stack_full = 1'b0;
    logic [1:0] ack_wait = 2'h0;
    logic ret_go = 1'b0;
    logic use_return_from_interrupt = 1'b1;
    logic [31:0] reg_rdata;
    logic [15:0] core_pc, call_vector, push_pc_value;
    logic call_ack, plain_return, return_from_interrupt, call_req, push_pc, wake_up, irq;
    int failures = 0;
    int checks = 0;
    int wakes = 0;
    int cyc = 0;

    always #4 core_clk = ~core_clk;

    mfi_merge mfi_merge_i (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .conversion_done(src[0]), .serial_port_status_flags(ser), .eeprom_write_end(src[2]),
        .supply_drop_detector(src[3]), .tm_match_a({src[6], src[4]}), .tm_match_p({src[7], src[5]}),
        .stack_full(stack_full), .core_pc(core_pc), .call_ack(call_ack), .plain_return(plain_return),
        .return_from_interrupt(return_from_interrupt), .call_req(call_req), .call_vector(call_vector),
        .push_pc(push_pc), .push_pc_value(push_pc_value), .wake_up(wake_up), .irq(irq));
    mfi_core_model mfi_core_model_i (.core_clk(core_clk), .reset(reset), .call_req(call_req),
        .ack_wait(ack_wait), .ret_go(ret_go), .use_return_from_interrupt(use_return_from_interrupt), .call_ack(call_ack),
        .plain_return(plain_return), .return_from_interrupt(return_from_interrupt), .core_pc(core_pc));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    task automatic fire(input logic [7:0] m, input logic [5:0] sm);
        @(posedge core_clk);
        src <= m;
        ser <= sm;
        @(posedge core_clk);
        src <= 8'h00;
        ser <= 6'h00;
    endtask : fire

    task automatic ret();
        @(posedge core_clk);
        ret_go <= 1'b1;
        @(posedge core_clk);
        ret_go <= 1'b0;
    endtask : ret

    // Waits for the call, checks its vector, then lets the model accept it
    task automatic serve(input logic [15:0] vec);
        int n;
        n = 0;
        #1;
        while (call_req !== 1'b1 && n < 40)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk({16'h0, call_vector}, {16'h0, vec});
        while (call_req === 1'b1 && n < 60)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask : serve

    // Quiet line check: no call may start for a while
    task automatic no_call();
        repeat (20)
        begin
            @(posedge core_clk);
            #1;
            chk({31'h0, call_req}, 32'h0);
        end
    endtask : no_call

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        logic [3:0] a[6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h7, 4'hc};
        logic [31:0] e[6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h10};
        foreach (a[i])
            rd(a[i], e[i]);
        wr(4'h1, 32'hff);
        rd(4'h1, 32'h3f);
    endtask : t_reset

    // Every source, every serial condition, every channel, slow and prompt acks
    task automatic t_vec();
        int s, b, ch, w0;
        wr(4'h3, 32'hff);
        wr(4'h0, 32'h1);
        for (int k = 0; k < 13; k++)
        begin
            s = (k < 8) ? k : 1;
            b = (k == 1) ? 5 : k - 8;
            ch = k % 6;
            ack_wait <= 2'(k);
            wr(4'h7, ch << (3 * s));
            w0 = wakes;
            fire((s == 1) ? 8'h00 : 8'h01 << s, (s == 1) ? 6'h01 << b : 6'h00);
            serve(16'(16 + ch * 4));
            chk(wakes - w0, 1);
            rd(4'h2, 32'h0);
            rd(4'h0, 32'h0);
            rd(4'h4, 32'h1 << s);
            wr(4'h6, 32'h1 << s);
            ret();
            rd(4'h0, 32'h1);
        end
    endtask : t_vec

    task automatic t_plain();
        int w0;
        use_return_from_interrupt <= 1'b0;
        wr(4'h0, 32'h0);
        wr(4'h7, 32'h43);
        fire(8'h05, 6'h00);
        rd(4'h2, 32'h0a);
        wr(4'h0, 32'h1);
        serve(16'h0014);
        ret();
        rd(4'h0, 32'h0);
        no_call();
        rd(4'h2, 32'h08);
        // Software preset of the flag, then its next event must stay silent
        wr(4'h6, 32'h01);
        wr(4'h5, 32'h01);
        repeat (3) @(posedge core_clk);
        w0 = wakes;
        fire(8'h01, 6'h00);
        repeat (4) @(posedge core_clk);
        chk(wakes - w0, 0);
        stack_full <= 1'b1;
        wr(4'h0, 32'h1);
        repeat (20)
        begin
            @(posedge core_clk);
            #1;
            chk({31'h0, call_req}, 32'h0);
        end
        stack_full <= 1'b0;
        use_return_from_interrupt <= 1'b1;
        serve(16'h001c);
        ret();
        wr(4'h6, 32'hff);
        // Source enable off: flag rises, channel stays quiet
        wr(4'h3, 32'h00);
        fire(8'h01, 6'h00);
        rd(4'h2, 32'h0);
        rd(4'h4, 32'h1);
        wr(4'h6, 32'hff);
    endtask : t_plain

    task automatic t_irq();
        wr(4'ha, 32'h1);
        repeat (2) @(posedge core_clk);
        #1;
        chk({31'h0, irq}, 32'h1);
        wr(4'h9, 32'h1);
        rd(4'h8, 32'h6);
        chk({31'h0, irq}, 32'h0);
        wr(4'h9, 32'h6);
        wr(4'ha, 32'h0);
        wr(4'hf, 32'hff);
        rd(4'hf, 32'h0);
        rd(4'h8, 32'h0);
        // Clock enable low: the write must not land
        clk_en <= 1'b0;
        wr(4'h1, 32'h0);
        clk_en <= 1'b1;
        rd(4'h1, 32'h3f);
    endtask : t_irq

    // ----------------------------------------------------------------
    // Run control
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    always @(posedge core_clk)
    begin
        cyc++;
        if (wake_up === 1'b1)
            wakes++;
        if (cyc == 20000)
        begin
            failures++;
            end_of_test();
        end
    end

    initial
    begin
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        t_reset();
        t_vec();
        t_plain();
        t_irq();
        end_of_test();
    end
endmodule : test_multi_function_interrupt_merge
